// *** src/adc_channel_output_control.sv ***
// Digital control and output stage of one converter channel with APB status and interrupt
//
// Overview of operation
// - All conversion logic runs on channel clock
// - Stabilizer pin high enables duty stabilizer
// - Format pin low offset binary, high twos
// - Power-down pin high powers channel down
// - Powered down outputs hold static, stay driven
// - Output enable low drives the data bus
// - Output enable high releases the data bus
// - Parallel word, bit zero least significant
// - Dedicated out-of-range indicator output
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module adc_channel_output_control #(
    parameter int LATENCY     = adc_chan_pkg::PIPE_LATENCY,
    parameter int WAKE_CYCLES = adc_chan_pkg::WAKE_CYCLES
) (
    // Channel clock and reset
    input  wire logic                                core_clk_i,
    input  wire logic                                nrst_i,
    // Converter core result, one per clock
    input  wire logic [adc_chan_pkg::DATA_W-1:0]     conv_code_i,
    input  wire logic                                conv_ovr_i,
    // Control pins
    input  wire logic                                duty_stabilizer_enable_i,
    input  wire logic                                output_coding_select_i,
    input  wire logic                                chan_b_power_down_i,
    input  wire logic                                chan_b_output_enable_n_i,
    // Output pins, with output enable for the three-state drivers
    output logic      [adc_chan_pkg::DATA_W-1:0]     chan_b_data_o,
    output logic                                     chan_b_data_oe_o,
    output logic                                     chan_b_range_overflow_o,
    output logic                                     chan_b_range_overflow_oe_o,
    // Controls toward the analog core
    output logic                                     duty_stabilizer_on_o,
    output logic                                     chan_power_down_o,
    // APB slave
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [adc_chan_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [adc_chan_pkg::APB_DATA_W-1:0] pwdata_i,
    output logic      [adc_chan_pkg::APB_DATA_W-1:0] prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    // Interrupt
    output logic                                     irq_o
);

    // Elaboration checks on parameters
    if (LATENCY < 2) begin : g_bad_latency
        $error("LATENCY must be at least two cycles");
    end
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << adc_chan_pkg::WAKE_CNT_W)) begin : g_bad_wake
        $error("WAKE_CYCLES does not fit the wake counter");
    end

    localparam int WORD_W = $bits(adc_chan_pkg::conv_word_t);   // Carrier width
    localparam logic [adc_chan_pkg::WAKE_CNT_W-1:0] WAKE_LOAD =
        adc_chan_pkg::WAKE_CNT_W'(WAKE_CYCLES);                // Countdown start
    localparam logic [adc_chan_pkg::WAKE_CNT_W-1:0] WAKE_ZERO = '0;   // Countdown end

    adc_chan_pkg::chan_state_t s_r;                    // Registered state
    adc_chan_pkg::chan_state_t s_nxt;                  // Next state

    adc_chan_pkg::conv_word_t  conv_in;                // Word entering the pipeline
    adc_chan_pkg::conv_word_t  conv_late;              // Word leaving the delay line
    logic [WORD_W-1:0]         late_bits;              // Raw delay line output

    logic                      pd_eff;                 // Pin or software power-down
    logic [adc_chan_pkg::IRQ_W-1:0] ev;                // Events this cycle
    logic                      apb_setup;              // Setup phase of a transfer
    logic                      apb_access;             // Access phase of a transfer
    logic                      addr_hit;               // Address maps to a register
    logic [adc_chan_pkg::DATA_W-1:0] coded;            // Word in selected coding

    // Word and flag travel as one carrier
    // flag beside word
    assign conv_in.code = conv_code_i;
    assign conv_in.ovr  = conv_ovr_i;

    // Delay line covers all but the output register stage
    // single channel clock
    sample_delay_line #(
        .W     (WORD_W),
        .DEPTH (LATENCY - 1)
    ) u_delay (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .hold_i     (pd_eff),
        .din_i      (conv_in),
        .dout_o     (late_bits)
    );

    assign conv_late = adc_chan_pkg::conv_word_t'(late_bits);

    // Power-down request from pin or register
    // pin high powers down
    assign pd_eff = chan_b_power_down_i | s_r.soft_pd;

    // Output coding: twos complement flips the top bit of offset binary
    // select output coding
    always_comb begin
        coded                           = conv_late.code;
        coded[adc_chan_pkg::DATA_W-1]   = conv_late.code[adc_chan_pkg::DATA_W-1] ^ output_coding_select_i;
    end

    // APB phase decode
    assign apb_setup  = psel_i & ~penable_i;
    assign apb_access = psel_i & penable_i;

    // Address decode over the mapped words
    always_comb begin
        unique case (paddr_i)
            adc_chan_pkg::REG_CTRL,
            adc_chan_pkg::REG_STATUS,
            adc_chan_pkg::REG_IRQ_STAT,
            adc_chan_pkg::REG_IRQ_MASK,
            adc_chan_pkg::REG_LAST_WORD,
            adc_chan_pkg::REG_OVR_COUNT: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Next-state logic for the whole channel
    always_comb begin
        s_nxt = s_r;
        ev    = '0;

        // Pin levels taken into state each cycle
        // stabilizer follows pin
        s_nxt.dcs_on = duty_stabilizer_enable_i;
        s_nxt.twos   = output_coding_select_i;
        s_nxt.pd     = pd_eff;

        // Entering power-down raises an event
        if (pd_eff && !s_r.pd) begin
            ev[adc_chan_pkg::IRQ_PD_BIT] = 1'b1;
        end

        // Wake-up countdown after power-down release
        if (pd_eff) begin
            // Restart the full wake time
            s_nxt.awake    = 1'b0;
            s_nxt.wake_cnt = WAKE_LOAD;
        end else if (s_r.wake_cnt != WAKE_ZERO) begin
            // Still settling
            s_nxt.wake_cnt = s_r.wake_cnt - 1'b1;
        end else if (!s_r.awake) begin
            // Countdown finished this cycle
            s_nxt.awake                     = 1'b1;
            ev[adc_chan_pkg::IRQ_WAKE_BIT]  = 1'b1;
        end

        // Output register: new word only while running and awake
        // outputs static in power-down
        if (!pd_eff && s_r.awake) begin
            s_nxt.out.code = coded;
            s_nxt.out.ovr  = conv_late.ovr;
            if (conv_late.ovr) begin
                ev[adc_chan_pkg::IRQ_OVR_BIT] = 1'b1;
                // Saturating count of overflow words
                if (s_r.ovr_count != '1) begin
                    s_nxt.ovr_count = s_r.ovr_count + 1'b1;
                end
            end
        end

        // Read data captured in the setup phase
        if (apb_setup && !pwrite_i) begin
            s_nxt.prdata = '0;
            unique case (paddr_i)
                adc_chan_pkg::REG_CTRL: begin
                    s_nxt.prdata[adc_chan_pkg::CTRL_SOFT_PD_BIT] = s_r.soft_pd;
                end
                adc_chan_pkg::REG_STATUS: begin
                    s_nxt.prdata[adc_chan_pkg::STAT_PD_BIT]    = s_r.pd;
                    s_nxt.prdata[adc_chan_pkg::STAT_AWAKE_BIT] = s_r.awake;
                    s_nxt.prdata[adc_chan_pkg::STAT_DCS_BIT]   = s_r.dcs_on;
                    s_nxt.prdata[adc_chan_pkg::STAT_TWOS_BIT]  = s_r.twos;
                    s_nxt.prdata[adc_chan_pkg::STAT_OE_BIT]    = ~chan_b_output_enable_n_i;
                end
                adc_chan_pkg::REG_IRQ_STAT: begin
                    s_nxt.prdata[adc_chan_pkg::IRQ_W-1:0] = s_r.irq_stat;
                end
                adc_chan_pkg::REG_IRQ_MASK: begin
                    s_nxt.prdata[adc_chan_pkg::IRQ_W-1:0] = s_r.irq_mask;
                end
                adc_chan_pkg::REG_LAST_WORD: begin
                    s_nxt.prdata[adc_chan_pkg::DATA_W-1:0]     = s_r.out.code;
                    s_nxt.prdata[adc_chan_pkg::LAST_OVR_BIT]   = s_r.out.ovr;
                end
                adc_chan_pkg::REG_OVR_COUNT: begin
                    s_nxt.prdata[adc_chan_pkg::OVR_CNT_W-1:0]  = s_r.ovr_count;
                end
                default: begin
                    // Unmapped reads return zero
                    s_nxt.prdata = '0;
                end
            endcase
        end

        // Writes take effect in the access phase
        if (apb_access && pwrite_i && addr_hit) begin
            unique case (paddr_i)
                adc_chan_pkg::REG_CTRL: begin
                    s_nxt.soft_pd = pwdata_i[adc_chan_pkg::CTRL_SOFT_PD_BIT];
                end
                adc_chan_pkg::REG_IRQ_STAT: begin
                    // Write one clears
                    s_nxt.irq_stat = s_r.irq_stat & ~pwdata_i[adc_chan_pkg::IRQ_W-1:0];
                end
                adc_chan_pkg::REG_IRQ_MASK: begin
                    s_nxt.irq_mask = pwdata_i[adc_chan_pkg::IRQ_W-1:0];
                end
                adc_chan_pkg::REG_OVR_COUNT: begin
                    // Any write restarts the count
                    s_nxt.ovr_count = '0;
                end
                default: begin
                    // Read-only words ignore writes
                    s_nxt.soft_pd = s_nxt.soft_pd;
                end
            endcase
        end

        // New events set after any clear, so a set wins
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
    end

    // State register with synchronous reset to constants
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_r          <= '0;
            s_r.irq_mask <= adc_chan_pkg::IRQ_MASK_RST;
            s_r.wake_cnt <= WAKE_LOAD;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Data pins from the output register
    // parallel word out
    assign chan_b_data_o           = s_r.out.code;
    assign chan_b_range_overflow_o = s_r.out.ovr;

    // Drivers follow only the enable pin, never power-down
    // enable low drives
    assign chan_b_data_oe_o           = ~chan_b_output_enable_n_i;
    assign chan_b_range_overflow_oe_o = ~chan_b_output_enable_n_i;

    // Analog core controls
    assign duty_stabilizer_on_o = s_r.dcs_on;
    assign chan_power_down_o    = s_r.pd;

    // Zero wait state APB answer
    assign pready_o  = apb_access;
    assign pslverr_o = apb_access & ~addr_hit;
    assign prdata_o  = s_r.prdata;

    // Level interrupt from unmasked sticky bits
    assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

endmodule

// *** src/adc_chan_pkg.sv ***
// Shared constants, register map and carrier types for the converter channel output block
package adc_chan_pkg;

    // Data path widths
    localparam int DATA_W        = 12;                 // Output word width
    localparam int PIPE_LATENCY  = 7;                  // Sample to output, in clock cycles
    localparam int OVR_CNT_W     = 16;                 // Overflow counter width

    // Timing: wake-up after power-down release
    localparam int CLK_PERIOD_NS = 10;                 // Core clock period
    localparam int WAKE_TIME_US  = 2500;               // Wake-up time in microseconds
    localparam int WAKE_CYCLES   = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W    = 18;                 // Wake counter width

    // APB geometry
    localparam int APB_ADDR_W    = 12;                 // Byte address width
    localparam int APB_DATA_W    = 32;                 // Bus data width

    // Register byte offsets
    localparam logic [11:0] REG_CTRL      = 12'h000;   // Control
    localparam logic [11:0] REG_STATUS    = 12'h004;   // Live status
    localparam logic [11:0] REG_IRQ_STAT  = 12'h008;   // Sticky events, write one to clear
    localparam logic [11:0] REG_IRQ_MASK  = 12'h00C;   // Interrupt enables
    localparam logic [11:0] REG_LAST_WORD = 12'h010;   // Last presented word
    localparam logic [11:0] REG_OVR_COUNT = 12'h014;   // Out-of-range word count

    // Control register fields
    localparam int CTRL_SOFT_PD_BIT   = 0;             // Software power-down request

    // Status register fields
    localparam int STAT_PD_BIT        = 0;             // Channel powered down
    localparam int STAT_AWAKE_BIT     = 1;             // Wake-up time elapsed
    localparam int STAT_DCS_BIT       = 2;             // Duty stabilizer enabled
    localparam int STAT_TWOS_BIT      = 3;             // Twos complement coding
    localparam int STAT_OE_BIT        = 4;             // Data bus driven

    // Last word register fields
    localparam int LAST_OVR_BIT       = 16;            // Overflow flag position

    // Interrupt event bits
    localparam int IRQ_W              = 3;             // Number of event bits
    localparam int IRQ_OVR_BIT        = 0;             // Out-of-range word presented
    localparam int IRQ_PD_BIT         = 1;             // Channel entered power-down
    localparam int IRQ_WAKE_BIT       = 2;             // Channel finished waking

    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;  // All interrupts masked

    // One converted result with its range flag
    typedef struct packed {
        logic [DATA_W-1:0] code;                       // Result code
        logic              ovr;                        // Input beyond range
    } conv_word_t;

    // Whole state of the channel controller
    typedef struct packed {
        logic                  soft_pd;                // Software power-down
        logic [IRQ_W-1:0]      irq_stat;               // Sticky events
        logic [IRQ_W-1:0]      irq_mask;               // Event enables
        logic                  pd;                     // Power-down state
        logic                  awake;                  // Wake time complete
        logic [WAKE_CNT_W-1:0] wake_cnt;               // Wake-up countdown
        conv_word_t            out;                    // Presented word
        logic [OVR_CNT_W-1:0]  ovr_count;              // Overflow words seen
        logic [APB_DATA_W-1:0] prdata;                 // Read data register
        logic                  dcs_on;                 // Stabilizer state
        logic                  twos;                   // Coding in use
    } chan_state_t;

endpackage

// *** src/sample_delay_line.sv ***
// Parameterised delay line that carries converted words through the pipeline
`timescale 1ns/1ps
module sample_delay_line #(
    parameter int W     = 13,
    parameter int DEPTH = 6
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    // Stall while powered down
    input  wire logic         hold_i,
    // Word in and out
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o
);

    // Elaboration check on the geometry
    if (DEPTH < 1 || W < 1) begin : g_bad_geometry
        $error("sample_delay_line needs DEPTH and W of at least one");
    end

    // All stages in one packed state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] stg;                  // Stage 0 is the newest
    } line_state_t;

    line_state_t s_r;                                  // Registered state
    line_state_t s_nxt;                                // Next state

    // Shift one place per cycle unless held
    always_comb begin
        s_nxt = s_r;
        if (!hold_i) begin
            s_nxt.stg[0] = din_i;
            for (int i = 1; i < DEPTH; i++) begin
                s_nxt.stg[i] = s_r.stg[i-1];
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Oldest stage leaves the line
    assign dout_o = s_r.stg[DEPTH-1];

endmodule

// *** tb/chan_out_checker.sv ***
// Assertions on the channel output block ports
`timescale 1ns/1ps
module chan_out_checker #(
    parameter int LATENCY     = 7,
    parameter int WAKE_CYCLES = 8
) (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    // Converter result and control pins
    input wire logic [11:0] conv_code_i,
    input wire logic        conv_ovr_i,
    input wire logic        duty_stabilizer_enable_i,
    input wire logic        output_coding_select_i,
    input wire logic        chan_b_power_down_i,
    input wire logic        chan_b_output_enable_n_i,
    // Outputs of the block
    input wire logic [11:0] chan_b_data_o,
    input wire logic        chan_b_data_oe_o,
    input wire logic        chan_b_range_overflow_o,
    input wire logic        chan_b_range_overflow_oe_o,
    input wire logic        duty_stabilizer_on_o,
    input wire logic        chan_power_down_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // Wake time plus two pipeline passes before words must flow
    localparam int RUN_MIN = WAKE_CYCLES + 2 * LATENCY + 4;
    logic [7:0] run_r;      // Cycles since power-down ended
    // Saturating count, cleared while powered down
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || chan_power_down_o) begin
            run_r <= 8'h00;
        end else if (run_r != 8'hFF) begin
            run_r <= run_r + 8'h01;
        end
    end
    property p_oe_pin; chan_b_data_oe_o == !chan_b_output_enable_n_i; endproperty
    a_oe_pin: assert property (p_oe_pin) else $error("bus enable off pin");
    property p_oe_off; chan_b_output_enable_n_i |-> !chan_b_range_overflow_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("flag driven when off");
    property p_dcs; $changed(duty_stabilizer_enable_i) |=> duty_stabilizer_on_o == $past(duty_stabilizer_enable_i);
    endproperty
    a_dcs: assert property (p_dcs) else $error("stabilizer not following");
    property p_pd_in; chan_b_power_down_i |=> chan_power_down_o; endproperty
    a_pd_in: assert property (p_pd_in) else $error("no power-down");
    property p_pd_hold; chan_power_down_o ##1 chan_power_down_o |-> $stable({chan_b_range_overflow_o, chan_b_data_o});
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("output moved in power-down");
    property p_pd_drive; chan_power_down_o && !chan_b_output_enable_n_i |-> chan_b_data_oe_o; endproperty
    a_pd_drive: assert property (p_pd_drive) else $error("bus released in power-down");
    property p_word; run_r >= RUN_MIN && !chan_power_down_o |->
        chan_b_data_o == ($past(conv_code_i, LATENCY) ^ {$past(output_coding_select_i), 11'h000}); endproperty
    a_word: assert property (p_word) else $error("output word wrong");
    property p_ovr; run_r >= RUN_MIN && !chan_power_down_o |->
        chan_b_range_overflow_o == $past(conv_ovr_i, LATENCY); endproperty
    a_ovr: assert property (p_ovr) else $error("range flag misaligned");
    c_pd: cover property (chan_power_down_o ##1 !chan_power_down_o);
    c_off: cover property (!chan_b_data_oe_o);
    c_ovr: cover property (chan_b_range_overflow_o);
endmodule
bind adc_channel_output_control chan_out_checker #(.LATENCY(LATENCY), .WAKE_CYCLES(WAKE_CYCLES)) chk_i (.*);

// *** tb/capture_sink.sv ***
// Downstream capture logic model on the channel data bus
`timescale 1ns/1ps
module capture_sink (
    // Clock
    input  wire logic        core_clk_i,
    // Bus pins with their enables
    input  wire logic [11:0] data_i,
    input  wire logic        data_oe_i,
    input  wire logic        ovr_i,
    input  wire logic        ovr_oe_i,
    // Coding this side selects
    input  wire logic        coding_i,
    // Wire level and captured word
    output logic      [11:0] bus_o,
    output logic      [11:0] cap_code_o,
    output logic             cap_ovr_o
);
    logic [11:0] last_r;    // Last wire level
    logic        ovr_r;     // Last flag level
    logic        ovr_w;     // Flag wire level
    // Released lines float: show inverse of last level
    assign bus_o = data_oe_i ? data_i : ~last_r;
    assign ovr_w = ovr_oe_i ? ovr_i : ~ovr_r;
    always_ff @(posedge core_clk_i) begin
        last_r     <= bus_o;
        ovr_r      <= ovr_w;
        cap_code_o <= bus_o ^ {coding_i, 11'h000};
        cap_ovr_o  <= ovr_w;
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the channel output block
`timescale 1ns/1ps
module tb_top;
    localparam int LAT  = 7;
    localparam int WAKE = 8;
    // Bench-driven pins
    logic        core_clk_i, nrst_i, conv_ovr_i, duty_stabilizer_enable_i, output_coding_select_i;
    logic        chan_b_power_down_i, chan_b_output_enable_n_i, psel_i, penable_i, pwrite_i;
    logic [11:0] conv_code_i, paddr_i, chan_b_data_o, bus_w, cap_code;
    logic [31:0] pwdata_i, prdata_o;
    // Block and model outputs
    logic        chan_b_data_oe_o, chan_b_range_overflow_o, chan_b_range_overflow_oe_o, duty_stabilizer_on_o;
    logic        chan_power_down_o, pready_o, pslverr_o, irq_o, cap_ovr;
    int          err_count, n_compared, cyc;
    adc_channel_output_control #(.LATENCY(LAT), .WAKE_CYCLES(WAKE)) adc_channel_output_control_i (.*);
    capture_sink capture_sink_i (.core_clk_i, .data_i(chan_b_data_o), .data_oe_i(chan_b_data_oe_o),
        .ovr_i(chan_b_range_overflow_o), .ovr_oe_i(chan_b_range_overflow_oe_o),
        .coding_i(output_coding_select_i), .bus_o(bus_w), .cap_code_o(cap_code), .cap_ovr_o(cap_ovr));
    // Compare and count
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic clk(int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // One APB transfer, held until pready at an edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd, output logic er);
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    // Mask reset value and unmapped places
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(adc_chan_pkg::REG_IRQ_MASK, r);
        chk("mask reset", r, 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk("unmapped rd err", 32'(e), 32'h1);
        chk("unmapped rd data", r, 32'h0);
        apb(1'b1, 12'h024, 32'hFFFF_FFFF, r, e);
        chk("unmapped wr err", 32'(e), 32'h1);
        $display("done regs");
    endtask
    // Bus release and drive by the enable pin
    task automatic t_oe();
        logic [31:0] r;
        @(posedge core_clk_i);
        chan_b_output_enable_n_i <= 1'b1;
        #1;
        chk("bus oe off", 32'(chan_b_data_oe_o), 32'h0);
        chk("flag oe off", 32'(chan_b_range_overflow_oe_o), 32'h0);
        rd(adc_chan_pkg::REG_STATUS, r);
        chk("status bus bit", 32'(r[4]), 32'h0);
        chan_b_output_enable_n_i <= 1'b0;
        clk(1);
        #1;
        chk("bus oe on", 32'(chan_b_data_oe_o), 32'h1);
        $display("done oe");
    endtask
    // Stabilizer on and off
    task automatic t_dcs();
        logic [31:0] r;
        @(posedge core_clk_i);
        duty_stabilizer_enable_i <= 1'b1;
        clk(2);
        #1;
        chk("stab on", 32'(duty_stabilizer_on_o), 32'h1);
        rd(adc_chan_pkg::REG_STATUS, r);
        chk("status stab", 32'(r[2]), 32'h1);
        duty_stabilizer_enable_i <= 1'b0;
        clk(2);
        #1;
        chk("stab off", 32'(duty_stabilizer_on_o), 32'h0);
        $display("done dcs");
    endtask
    // Power-down holds a driven static word, then wakes
    task automatic t_pd();
        logic [31:0] r;
        logic [11:0] held;
        @(posedge core_clk_i);
        chan_b_power_down_i <= 1'b1;
        clk(2);
        #1;
        chk("pd out", 32'(chan_power_down_o), 32'h1);
        held = chan_b_data_o;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk_i);
            conv_code_i <= conv_code_i + 12'h155;
        end
        #1;
        chk("held word", chan_b_data_o, held);
        chk("still driven", 32'(chan_b_data_oe_o), 32'h1);
        rd(adc_chan_pkg::REG_IRQ_STAT, r);
        chk("pd event", 32'(r[1]), 32'h1);
        chan_b_power_down_i <= 1'b0;
        clk(WAKE + 2 * LAT + 6);
        rd(adc_chan_pkg::REG_IRQ_STAT, r);
        chk("wake event", 32'(r[2]), 32'h1);
        wr(adc_chan_pkg::REG_IRQ_STAT, 32'h7);
        rd(adc_chan_pkg::REG_IRQ_STAT, r);
        chk("events cleared", r, 32'h0);
        $display("done pd");
    endtask
    // Back-to-back boundary words in one coding
    task automatic t_stream(logic sel);
        logic [11:0] w [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            output_coding_select_i <= sel;
            conv_code_i            <= w[i];
            conv_ovr_i             <= 1'(i == 1);
        end
        @(posedge core_clk_i);
        conv_ovr_i <= 1'b0;
        clk(LAT - 4);
        for (int i = 0; i < 4; i++) begin
            #1;
            chk("word", chan_b_data_o, w[i] ^ {sel, 11'h000});
            chk("wire", bus_w, w[i] ^ {sel, 11'h000});
            chk("flag", 32'(chan_b_range_overflow_o), 32'(i == 1));
            if (i > 0) chk("capture", cap_code, w[i - 1]);
            if (i > 0) chk("capture flag", 32'(cap_ovr), 32'(i == 2));
            @(posedge core_clk_i);
        end
        $display("done stream");
    endtask
    // Interrupt raise, mask, clear and soft power-down
    task automatic t_irq();
        wr(adc_chan_pkg::REG_IRQ_MASK, 32'h1);
        clk(1);
        #1;
        chk("irq raised", 32'(irq_o), 32'h1);
        wr(adc_chan_pkg::REG_IRQ_MASK, 32'h0);
        clk(1);
        #1;
        chk("irq masked", 32'(irq_o), 32'h0);
        wr(adc_chan_pkg::REG_IRQ_MASK, 32'h1);
        wr(adc_chan_pkg::REG_IRQ_STAT, 32'h1);
        clk(1);
        #1;
        chk("irq cleared", 32'(irq_o), 32'h0);
        wr(adc_chan_pkg::REG_CTRL, 32'h1);
        clk(2);
        #1;
        chk("soft pd", 32'(chan_power_down_o), 32'h1);
        wr(adc_chan_pkg::REG_CTRL, 32'h0);
        $display("done irq");
    endtask
    // Free-running clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    // Main sequence
    initial begin
        {nrst_i, conv_ovr_i, duty_stabilizer_enable_i, output_coding_select_i} = 4'h0;
        {chan_b_power_down_i, chan_b_output_enable_n_i, psel_i, penable_i, pwrite_i} = 5'h00;
        conv_code_i = 12'h000;
        paddr_i     = 12'h000;
        pwdata_i    = 32'h0;
        clk(8);
        nrst_i <= 1'b1;
        clk(WAKE + 2 * LAT + 6);
        t_regs();
        t_oe();
        t_dcs();
        t_pd();
        t_stream(1'b0);
        t_stream(1'b1);
        t_irq();
        close_out();
    end
endmodule
